// [hdl/dlycal_pkg.sv]
// Constants for the link delay calibration register bank
// Summary of operation
// - Override enable makes software TX delay win
// - Software TX delay used only when enabled
// - Expose 16-bit computed master-to-slave delay
// - Report round-trip state in bits 29:28
// - Top control bit resets calibration block
// - Middle control bit selects bypass mode
// - Lowest control bit turns calibration on
// - 20-bit target round-trip delay drives calibration
// - Override, current delay and receive control registers slave-only
// - Round-trip register master-only
// - Override beats stream-received TX delay
// - Whole-cycle adjustment is 8 bits
// - Fractional step adjustment is 9 bits
package dlycal_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_TX_OVR    = 8'h70;
   localparam logic [7:0] OFF_CUR_DLY   = 8'h74;
   localparam logic [7:0] OFF_RTD       = 8'h80;
   localparam logic [7:0] OFF_INT_STS   = 8'h90;
   localparam logic [7:0] OFF_INT_CLR   = 8'h94;
   localparam logic [7:0] OFF_INT_EN    = 8'h98;
   localparam logic [7:0] OFF_RCV_CTRL  = 8'ha0;
   // Field positions and widths
   localparam int TXD_W        = 12;
   localparam int TXD_EN_BIT   = 16;
   localparam int CUR_W        = 16;
   localparam int RTD_TGT_W    = 20;
   localparam int RTD_CTRL_LSB = 24;
   localparam int RTD_STS_LSB  = 28;
   localparam int CYC_W        = 8;
   localparam int STEP_W       = 9;
   localparam int INT_W        = 4;
   // Interrupt status bits
   localparam int INT_CUR_UPD  = 0;
   localparam int INT_RTD_DONE = 1;
   localparam int INT_RTD_ERR  = 2;
   localparam int INT_RX_DLY   = 3;
   // Writable field masks
   localparam logic [31:0] MSK_TX_OVR   = 32'h0001_0fff;
   localparam logic [31:0] MSK_RTD      = 32'h070f_ffff;
   localparam logic [31:0] MSK_INT      = 32'h0000_000f;
   localparam logic [31:0] MSK_RCV_CTRL = 32'h0000_0001;
   // Reset values
   localparam logic [31:0] RST_REG      = 32'h0000_0000;
   // Round-trip status codes
   localparam logic [1:0] RTD_STS_OFF  = 2'b00;
   localparam logic [1:0] RTD_STS_RUN  = 2'b01;
   localparam logic [1:0] RTD_STS_DONE = 2'b10;
   localparam logic [1:0] RTD_STS_ERR  = 2'b11;
   // Round-trip state machine, Gray along off-run-monitor
   typedef enum logic [1:0] {
      RTD_OFF = 2'b00,
      RTD_RUN = 2'b01,
      RTD_MON = 2'b11,
      RTD_ERR = 2'b10
   } dlycal_rtd_st_t;
endpackage : dlycal_pkg

// [hdl/dlycal_rtd_if.sv]
// Interface between register bank and round-trip calibrator
`timescale 1ns/10ps
interface dlycal_rtd_if;
   logic                               cal_reset;
   logic                               cal_bypass;
   logic                               cal_enable;
   logic [dlycal_pkg::RTD_TGT_W-1:0]   target;
   logic [dlycal_pkg::RTD_TGT_W-1:0]   meas;
   logic [dlycal_pkg::STEP_W-1:0]      meas_frac;
   logic                               meas_vld;
   logic [1:0]                         status;
   logic [dlycal_pkg::CYC_W-1:0]       cycle_adj;
   logic [dlycal_pkg::STEP_W-1:0]      step_adj;
   logic                               bypass_act;

   modport regs (output cal_reset, cal_bypass, cal_enable, target,
                 meas, meas_frac, meas_vld,
                 input  status, cycle_adj, step_adj, bypass_act);
   modport cal  (input  cal_reset, cal_bypass, cal_enable, target,
                 meas, meas_frac, meas_vld,
                 output status, cycle_adj, step_adj, bypass_act);
endinterface : dlycal_rtd_if

// [hdl/dlycal_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module dlycal_sync #(
   parameter int W = 1
) (
   // Clock, reset, enable
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          ce,
   // Data
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);
   logic [W-1:0] meta_r;

   initial
   begin
      if (W < 1) $error("dlycal_sync: width must be positive");
   end

   // First stage read only by second stage
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else if (ce)
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : dlycal_sync

// [hdl/dlycal_rtd_cal.sv]
// Round-trip delay calibrator state machine
`timescale 1ns/10ps
module dlycal_rtd_cal #(
   parameter int STEPS_PER_CYCLE = 256
) (
   // Clock, reset, enable
   input  wire logic   clk,
   input  wire logic   rst_b,
   input  wire logic   ce,
   // Register side
   dlycal_rtd_if.cal   rif
);
   dlycal_pkg::dlycal_rtd_st_t st_r;
   dlycal_pkg::dlycal_rtd_st_t st_nxt;
   logic [dlycal_pkg::RTD_TGT_W:0]   need;
   logic [dlycal_pkg::RTD_TGT_W-1:0] whole;
   logic                             has_frac;
   logic                             fits;
   logic [dlycal_pkg::STEP_W-1:0]    step_calc;

   initial
   begin
      if (STEPS_PER_CYCLE < 1 || STEPS_PER_CYCLE > 511)
         $error("dlycal_rtd_cal: STEPS_PER_CYCLE out of range");
   end

   // Adjustment needed to stretch measured delay to target
   assign has_frac  = (rif.meas_frac != '0);
   assign need      = {1'b0, rif.target} - {1'b0, rif.meas}
                      - {{dlycal_pkg::RTD_TGT_W{1'b0}}, has_frac};
   assign whole     = need[dlycal_pkg::RTD_TGT_W-1:0];
   assign fits      = !need[dlycal_pkg::RTD_TGT_W]
                      && (whole < (1 << dlycal_pkg::CYC_W));
   assign step_calc = has_frac
                      ? dlycal_pkg::STEP_W'(STEPS_PER_CYCLE) - rif.meas_frac
                      : '0;

   // Next state: reset beats bypass beats enable
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         dlycal_pkg::RTD_OFF:
            if (rif.cal_enable && !rif.cal_bypass)
               st_nxt = dlycal_pkg::RTD_RUN;
         dlycal_pkg::RTD_RUN:
            if (!rif.cal_enable || rif.cal_bypass)
               st_nxt = dlycal_pkg::RTD_OFF;
            else if (rif.meas_vld)
               st_nxt = fits ? dlycal_pkg::RTD_MON : dlycal_pkg::RTD_ERR;
         dlycal_pkg::RTD_MON:
            if (!rif.cal_enable || rif.cal_bypass)
               st_nxt = dlycal_pkg::RTD_OFF;
            else if (rif.meas_vld && !fits)
               st_nxt = dlycal_pkg::RTD_ERR;
         dlycal_pkg::RTD_ERR:
            st_nxt = dlycal_pkg::RTD_ERR;
         default:
            st_nxt = dlycal_pkg::RTD_OFF;
      endcase
      if (rif.cal_reset)
         st_nxt = dlycal_pkg::RTD_OFF;
   end

   // State, status and adjustment registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r           <= dlycal_pkg::RTD_OFF;
         rif.status     <= dlycal_pkg::RTD_STS_OFF;
         rif.cycle_adj  <= '0;
         rif.step_adj   <= '0;
         rif.bypass_act <= 1'b0;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
         case (st_nxt)
            dlycal_pkg::RTD_RUN: rif.status <= dlycal_pkg::RTD_STS_RUN;
            dlycal_pkg::RTD_MON: rif.status <= dlycal_pkg::RTD_STS_DONE;
            dlycal_pkg::RTD_ERR: rif.status <= dlycal_pkg::RTD_STS_ERR;
            default:             rif.status <= dlycal_pkg::RTD_STS_OFF;
         endcase
         rif.bypass_act <= rif.cal_bypass && !rif.cal_reset;
         if (rif.cal_reset || rif.cal_bypass || !rif.cal_enable)
         begin
            rif.cycle_adj <= '0;
            rif.step_adj  <= '0;
         end
         else if (rif.meas_vld && fits && st_r != dlycal_pkg::RTD_ERR)
         begin
            rif.cycle_adj <= whole[dlycal_pkg::CYC_W-1:0];
            rif.step_adj  <= step_calc;
         end
      end
   end
endmodule : dlycal_rtd_cal

// [hdl/dlycal_regs.sv]
// Delay calibration register bank with Wishbone slave
`timescale 1ns/10ps
module dlycal_regs #(
   parameter bit ROLE_MASTER     = 1'b0,
   parameter int STEPS_PER_CYCLE = 256
) (
   // Clock, reset, enable
   input  wire logic                               clk,
   input  wire logic                               rst_b,
   input  wire logic                               ce,
   // Wishbone slave
   input  wire logic                               wb_cyc_i,
   input  wire logic                               wb_stb_i,
   input  wire logic                               wb_we_i,
   input  wire logic [7:0]                         wb_adr_i,
   input  wire logic [3:0]                         wb_sel_i,
   input  wire logic [31:0]                        wb_dat_i,
   output logic      [31:0]                        wb_dat_o,
   output logic                                    wb_ack_o,
   // Interrupt
   output logic                                    irq,
   // Slave-role delay measurement pins
   input  wire logic                               delay_measure_clock,
   input  wire logic                               sync_master_mark,
   input  wire logic                               sync_local_mark,
   // Slave-role TX delay from incoming stream
   input  wire logic [dlycal_pkg::TXD_W-1:0]       link_tx_delay,
   input  wire logic                               link_tx_delay_vld,
   // Slave-role TX delay in use
   output logic      [dlycal_pkg::TXD_W-1:0]       tx_delay,
   output logic                                    tx_delay_vld,
   // Master-role round-trip measurement
   input  wire logic [dlycal_pkg::RTD_TGT_W-1:0]   rtd_meas,
   input  wire logic [dlycal_pkg::STEP_W-1:0]      rtd_meas_frac,
   input  wire logic                               rtd_meas_vld,
   // Master-role round-trip adjustment
   output logic      [dlycal_pkg::CYC_W-1:0]       rtd_cycle_adj,
   output logic      [dlycal_pkg::STEP_W-1:0]      rtd_step_adj,
   output logic                                    rtd_bypass
);
   localparam logic [dlycal_pkg::CUR_W-1:0] CUR_MAX = '1;

   // Register state
   logic [31:0]                     tx_ovr_r;
   logic [31:0]                     rtd_r;
   logic [31:0]                     rcv_ctrl_r;
   logic [dlycal_pkg::INT_W-1:0]    int_sts_r;
   logic [dlycal_pkg::INT_W-1:0]    int_sts_nxt;
   logic [dlycal_pkg::INT_W-1:0]    int_en_r;
   logic [dlycal_pkg::CUR_W-1:0]    cur_dly_r;
   logic [dlycal_pkg::CUR_W-1:0]    cnt_r;
   logic                            cnt_run_r;
   logic [2:0]                      pin_s;
   logic [2:0]                      pin_prev_r;
   logic [dlycal_pkg::TXD_W-1:0]    rx_dly_r;
   logic                            rx_dly_vld_r;
   logic [1:0]                      rtd_sts_prev_r;
   logic                            ack_r;
   logic [31:0]                     rdat_r;

   // Bus decode
   wire        bus_req   = wb_cyc_i && wb_stb_i && !ack_r;
   wire        bus_wr    = bus_req && wb_we_i;
   wire [31:0] byte_msk  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [7:0]  adr_w     = {wb_adr_i[7:2], 2'b00};
   wire        has_slv   = !ROLE_MASTER;
   wire        has_mst   = ROLE_MASTER;
   wire        sel_txo   = has_slv && adr_w == dlycal_pkg::OFF_TX_OVR;
   wire        sel_cur   = has_slv && adr_w == dlycal_pkg::OFF_CUR_DLY;
   wire        sel_rtd   = has_mst && adr_w == dlycal_pkg::OFF_RTD;
   wire        sel_rcv   = has_slv && adr_w == dlycal_pkg::OFF_RCV_CTRL;
   wire        sel_ists  = adr_w == dlycal_pkg::OFF_INT_STS;
   wire        sel_iclr  = adr_w == dlycal_pkg::OFF_INT_CLR;
   wire        sel_ien   = adr_w == dlycal_pkg::OFF_INT_EN;
   wire        wr_txo    = bus_wr && sel_txo;
   wire        wr_rtd    = bus_wr && sel_rtd;
   wire        wr_rcv    = bus_wr && sel_rcv;
   wire        wr_iclr   = bus_wr && sel_iclr;
   wire        wr_ien    = bus_wr && sel_ien;

   wire [31:0] txo_nxt   = ((tx_ovr_r & ~byte_msk) | (wb_dat_i & byte_msk))
                           & dlycal_pkg::MSK_TX_OVR;
   wire [31:0] rtd_nxt   = ((rtd_r & ~byte_msk) | (wb_dat_i & byte_msk))
                           & dlycal_pkg::MSK_RTD;
   wire [31:0] rcv_nxt   = ((rcv_ctrl_r & ~byte_msk)
                           | (wb_dat_i & byte_msk))
                           & dlycal_pkg::MSK_RCV_CTRL;
   wire [31:0] ien_nxt   = (({28'h0000000, int_en_r} & ~byte_msk)
                           | (wb_dat_i & byte_msk)) & dlycal_pkg::MSK_INT;
   wire [dlycal_pkg::INT_W-1:0] clr_bits =
      wr_iclr ? dlycal_pkg::INT_W'(wb_dat_i & byte_msk) : '0;

   // Software fields
   wire        usr_en    = tx_ovr_r[dlycal_pkg::TXD_EN_BIT];
   wire [dlycal_pkg::TXD_W-1:0] usr_dly = tx_ovr_r[dlycal_pkg::TXD_W-1:0];
   wire        rcv_en    = rcv_ctrl_r[0];

   // Synchronised measurement pins
   wire        dmc_s     = pin_s[0];
   wire        mst_s     = pin_s[1];
   wire        loc_s     = pin_s[2];
   wire        dmc_rise  = dmc_s && !pin_prev_r[0];
   wire        mst_rise  = mst_s && !pin_prev_r[1];
   wire        loc_rise  = loc_s && !pin_prev_r[2];
   wire        cur_done  = has_slv && cnt_run_r && loc_rise;

   // Stream delay capture, ignored under override
   // override beats stream capture
   wire        rx_take   = has_slv && rcv_en && !usr_en
                           && link_tx_delay_vld;

   // Round-trip events from calibrator status
   dlycal_rtd_if rif ();
   wire        rtd_done_ev = has_mst
                             && rif.status == dlycal_pkg::RTD_STS_DONE
                             && rtd_sts_prev_r != dlycal_pkg::RTD_STS_DONE;
   wire        rtd_err_ev  = has_mst
                             && rif.status == dlycal_pkg::RTD_STS_ERR
                             && rtd_sts_prev_r != dlycal_pkg::RTD_STS_ERR;

   // Read data mux, absent registers read zero
   wire [31:0] rd_txo  = sel_txo  ? tx_ovr_r : 32'h0000_0000;
   wire [31:0] rd_cur  = sel_cur  ? {16'h0000, cur_dly_r} : 32'h0000_0000;
   wire [31:0] rd_rtd  = sel_rtd
                         ? (rtd_r | {2'b00, rif.status, 28'h0000000})
                         : 32'h0000_0000;
   wire [31:0] rd_rcv  = sel_rcv  ? rcv_ctrl_r : 32'h0000_0000;
   wire [31:0] rd_ists = sel_ists ? {28'h0000000, int_sts_r}
                                  : 32'h0000_0000;
   wire [31:0] rd_ien  = sel_ien  ? {28'h0000000, int_en_r}
                                  : 32'h0000_0000;
   wire [31:0] rd_mux  = rd_txo | rd_cur | rd_rtd | rd_rcv
                         | rd_ists | rd_ien;

   // Calibrator drive
   // top control bit resets
   assign rif.cal_reset  = rtd_r[dlycal_pkg::RTD_CTRL_LSB+2];
   assign rif.cal_bypass = rtd_r[dlycal_pkg::RTD_CTRL_LSB+1];
   assign rif.cal_enable = rtd_r[dlycal_pkg::RTD_CTRL_LSB] && has_mst;
   assign rif.target     = rtd_r[dlycal_pkg::RTD_TGT_W-1:0];
   assign rif.meas       = rtd_meas;
   assign rif.meas_frac  = rtd_meas_frac;
   assign rif.meas_vld   = rtd_meas_vld && has_mst;

   // Master-role outputs from calibrator flops
   assign rtd_cycle_adj = rif.cycle_adj;
   assign rtd_step_adj  = rif.step_adj;
   assign rtd_bypass    = rif.bypass_act;

   // Sticky events, set wins over clear
   always_comb
   begin
      int_sts_nxt = int_sts_r & ~clr_bits;
      if (cur_done)
         int_sts_nxt[dlycal_pkg::INT_CUR_UPD] = 1'b1;
      if (rtd_done_ev)
         int_sts_nxt[dlycal_pkg::INT_RTD_DONE] = 1'b1;
      if (rtd_err_ev)
         int_sts_nxt[dlycal_pkg::INT_RTD_ERR] = 1'b1;
      if (rx_take)
         int_sts_nxt[dlycal_pkg::INT_RX_DLY] = 1'b1;
   end

   // Pin synchroniser
   dlycal_sync #(
      .W (3)
   ) u_pin_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .d     ({sync_local_mark, sync_master_mark, delay_measure_clock}),
      .q     (pin_s)
   );

   // Round-trip calibrator
   dlycal_rtd_cal #(
      .STEPS_PER_CYCLE (STEPS_PER_CYCLE)
   ) u_rtd_cal (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .rif   (rif.cal)
   );

   // Wishbone answer one cycle after request
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ack_r  <= 1'b0;
         rdat_r <= dlycal_pkg::RST_REG;
      end
      else if (ce)
      begin
         ack_r  <= bus_req;
         rdat_r <= bus_req && !wb_we_i ? rd_mux : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // Software-written registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_ovr_r   <= dlycal_pkg::RST_REG;
         rtd_r      <= dlycal_pkg::RST_REG;
         rcv_ctrl_r <= dlycal_pkg::RST_REG;
         int_en_r   <= '0;
      end
      else if (ce)
      begin
         if (wr_txo)
            tx_ovr_r <= txo_nxt;
         if (wr_rtd)
            rtd_r <= rtd_nxt;
         if (wr_rcv)
            rcv_ctrl_r <= rcv_nxt;
         if (wr_ien)
            int_en_r <= ien_nxt[dlycal_pkg::INT_W-1:0];
      end
   end

   // Interrupt status and line
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         int_sts_r      <= '0;
         irq            <= 1'b0;
         rtd_sts_prev_r <= dlycal_pkg::RTD_STS_OFF;
      end
      else if (ce)
      begin
         int_sts_r      <= int_sts_nxt;
         irq            <= |(int_sts_nxt & int_en_r);
         rtd_sts_prev_r <= rif.status;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_prev_r <= '0;
         cnt_r      <= '0;
         cnt_run_r  <= 1'b0;
         cur_dly_r  <= '0;
      end
      else if (ce)
      begin
         pin_prev_r <= pin_s;
         if (has_slv && mst_rise)
         begin
            cnt_r     <= '0;
            cnt_run_r <= 1'b1;
         end
         else if (cur_done)
         begin
            cnt_run_r <= 1'b0;
            cur_dly_r <= cnt_r;
         end
         else if (cnt_run_r && dmc_rise && cnt_r != CUR_MAX)
            cnt_r <= cnt_r + 1'b1;
      end
   end

   // Stream-received TX delay holder
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_dly_r     <= '0;
         rx_dly_vld_r <= 1'b0;
      end
      else if (ce)
      begin
         if (rx_take)
         begin
            rx_dly_r     <= link_tx_delay;
            rx_dly_vld_r <= 1'b1;
         end
         else if (!rcv_en)
            rx_dly_vld_r <= 1'b0;
      end
   end

   // TX delay in use
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_delay     <= '0;
         tx_delay_vld <= 1'b0;
      end
      else if (ce)
      begin
         if (has_slv && usr_en)
         begin
            tx_delay     <= usr_dly;
            tx_delay_vld <= 1'b1;
         end
         else if (has_slv && rx_dly_vld_r)
         begin
            tx_delay     <= rx_dly_r;
            tx_delay_vld <= 1'b1;
         end
         else
         begin
            tx_delay     <= '0;
            tx_delay_vld <= 1'b0;
         end
      end
   end
endmodule : dlycal_regs

// [verification/dlycal_props.sv]
// Assertion checker for the delay calibration register bank
`timescale 1ns/10ps
module dlycal_props #(
   parameter bit ROLE_MASTER = 1'b0
) (
   // Clock, reset, enable
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   input  wire logic                         ce,
   // Wishbone slave
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [7:0]                   wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   input  wire logic [31:0]                  wb_dat_o,
   input  wire logic                         wb_ack_o,
   // TX delay in use
   input  wire logic [dlycal_pkg::TXD_W-1:0] tx_delay,
   input  wire logic                         tx_delay_vld
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Request taken, read answered
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   endsequence
   sequence s_rd(a);
      wb_ack_o && !wb_we_i && wb_adr_i == a;
   endsequence
   property p_ack_resp; s_req |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
   property p_ovr_wins;
      s_req ##0 (wb_we_i && wb_adr_i == dlycal_pkg::OFF_TX_OVR
         && wb_dat_i[16] && wb_sel_i[2:0] == 3'h7 && !ROLE_MASTER)
      |-> ##2 tx_delay_vld && tx_delay == $past(wb_dat_i[11:0], 2);
   endproperty
   a_ovr_wins: assert property (p_ovr_wins) else $error("ovr lost");
   property p_rsv_ovr;
      s_rd(dlycal_pkg::OFF_TX_OVR)
      |-> (wb_dat_o & ~dlycal_pkg::MSK_TX_OVR) == 32'h0;
   endproperty
   a_rsv_ovr: assert property (p_rsv_ovr) else $error("rsv set");
   property p_rsv_cur;
      s_rd(dlycal_pkg::OFF_CUR_DLY) |-> wb_dat_o[31:16] == 16'h0;
   endproperty
   a_rsv_cur: assert property (p_rsv_cur) else $error("cur wide");
   property p_rsv_rtd;
      s_rd(dlycal_pkg::OFF_RTD) |-> wb_dat_o[31:30] == 2'h0
         && !wb_dat_o[27] && wb_dat_o[23:20] == 4'h0;
   endproperty
   a_rsv_rtd: assert property (p_rsv_rtd) else $error("rsv set");
   property p_role;
      s_rd(ROLE_MASTER ? dlycal_pkg::OFF_TX_OVR : dlycal_pkg::OFF_RTD)
      |-> wb_dat_o == 32'h0;
   endproperty
   a_role: assert property (p_role) else $error("absent reg");
endmodule : dlycal_props

bind dlycal_regs dlycal_props #(.ROLE_MASTER(ROLE_MASTER)) u_props (
   .clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .tx_delay(tx_delay), .tx_delay_vld(tx_delay_vld));

// [verification/tb_top.sv]
// Self-checking bench for the delay calibration register bank
`timescale 1ns/10ps
module tb_top;
   logic        clk, rst_b, ce, cyc, stb, we, mclk, mm, lm, lvld, rv, m;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat, q, dat_s, dat_m;
   logic [11:0] ltd, txd;
   logic [19:0] rm;
   logic [8:0]  rf, sadj;
   logic [7:0]  cadj;
   logic        ack_s, ack_m, irq_s, txv, byp;
   int          err_count, num_checks;
   // Slave and master role instances on one bus
   dlycal_regs #(.ROLE_MASTER(1'b0)) uut (.clk(clk), .rst_b(rst_b),
      .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_s), .wb_ack_o(ack_s),
      .irq(irq_s), .delay_measure_clock(mclk), .sync_master_mark(mm),
      .sync_local_mark(lm), .link_tx_delay(ltd), .link_tx_delay_vld(lvld),
      .tx_delay(txd), .tx_delay_vld(txv), .rtd_meas(rm), .rtd_meas_frac(rf),
      .rtd_meas_vld(rv), .rtd_cycle_adj(), .rtd_step_adj(), .rtd_bypass());
   dlycal_regs #(.ROLE_MASTER(1'b1)) uut_m (.clk(clk), .rst_b(rst_b),
      .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_m), .wb_ack_o(ack_m),
      .irq(), .delay_measure_clock(mclk), .sync_master_mark(mm),
      .sync_local_mark(lm), .link_tx_delay(ltd), .link_tx_delay_vld(lvld),
      .tx_delay(), .tx_delay_vld(), .rtd_meas(rm), .rtd_meas_frac(rf),
      .rtd_meas_vld(rv), .rtd_cycle_adj(cadj), .rtd_step_adj(sadj),
      .rtd_bypass(byp));
   // 20 MHz clock
   always #25 clk = ~clk;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task results;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   task w(input int n);
      repeat (n) @(posedge clk);
   endtask : w
   // Classic cycle, waits for ack, then releases
   task bus(input logic wr_, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr_;
      adr <= a;
      dat <= d;
      do @(posedge clk); while ((m ? ack_m : ack_s) !== 1'b1);
      q = m ? dat_m : dat_s;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task send(input logic [11:0] v);
      @(posedge clk);
      ltd <= v;
      lvld <= 1'b1;
      @(posedge clk);
      lvld <= 1'b0;
      w(3);
   endtask : send
   task meas(input logic [19:0] c, input logic [8:0] f);
      @(posedge clk);
      rm <= c;
      rf <= f;
      rv <= 1'b1;
      @(posedge clk);
      rv <= 1'b0;
      w(2);
   endtask : meas
   task t_rst;
      static logic [7:0] a[6] = '{8'h70, 8'h74, 8'h80, 8'h90, 8'h98, 8'ha0};
      foreach (a[i]) rd(a[i], 32'h0);
   endtask : t_rst
   task t_meas;
      wr(8'h98, 32'h1);
      mm <= 1'b1;
      w(6);
      repeat (5)
      begin
         mclk <= 1'b1;
         w(4);
         mclk <= 1'b0;
         w(4);
      end
      lm <= 1'b1;
      w(8);
      rd(8'h74, 32'h5);
      rd(8'h90, 32'h1);
      chk({31'h0, irq_s}, 32'h1);
      wr(8'h98, 32'h0);
      w(2);
      chk({31'h0, irq_s}, 32'h0);
      wr(8'h98, 32'h1);
      w(2);
      chk({31'h0, irq_s}, 32'h1);
      wr(8'h94, 32'hf);
      w(2);
      chk({31'h0, irq_s}, 32'h0);
      rd(8'h90, 32'h0);
      mm <= 1'b0;
      lm <= 1'b0;
   endtask : t_meas
   task t_ovr;
      wr(8'ha0, 32'h1);
      wr(8'h70, 32'h0000_0abc);
      send(12'h3a5);
      chk({20'h0, txd}, 32'h3a5);
      wr(8'h70, 32'hffff_f123);
      w(1);
      chk({20'h0, txd}, 32'h123);
      rd(8'h70, 32'h0001_0123);
      send(12'h456);
      chk({20'h0, txd}, 32'h123);
      wr(8'h70, 32'h0000_0123);
      send(12'h7e0);
      chk({20'h0, txd}, 32'h7e0);
   endtask : t_ovr
   task t_rtd;
      m = 1'b1;
      wr(8'h80, 32'hf1f0_0100);
      w(2);
      rd(8'h80, 32'h1100_0100);
      meas(20'h000f0, 9'h0);
      chk({24'h0, cadj}, 32'h10);
      rd(8'h80, 32'h2100_0100);
      meas(20'h000f0, 9'h040);
      chk({24'h0, cadj}, 32'h0f);
      chk({23'h0, sadj}, 32'h0c0);
      meas(20'h00200, 9'h0);
      rd(8'h80, 32'h3100_0100);
      rd(8'h90, 32'h6);
      wr(8'h80, 32'h0400_0100);
      w(2);
      rd(8'h80, 32'h0400_0100);
      wr(8'h80, 32'h0200_0100);
      w(2);
      chk({31'h0, byp}, 32'h1);
      wr(8'h80, 32'h0000_0100);
      w(2);
      chk({31'h0, byp}, 32'h0);
      rd(8'h80, 32'h0000_0100);
      rd(8'h70, 32'h0);
      m = 1'b0;
      rd(8'h80, 32'h0);
   endtask : t_rtd
   // Main sequence
   initial
   begin
      {clk, rst_b, cyc, stb, we, mclk, mm, lm, lvld, rv, m} = '0;
      {adr, sel, dat, ltd, rm, rf} = '0;
      ce = 1'b1;
      sel = 4'hf;
      w(20);
      rst_b <= 1'b1;
      t_rst;
      t_meas;
      t_ovr;
      t_rtd;
      results;
   end
   // Watchdog
   initial
   begin
      #2000000;
      err_count++;
      results;
   end
endmodule : tb_top
